// *** verilog/bmc_pkg.sv ***
`default_nettype none
package bmc_pkg;

   // ------------------------------------------------------------
   // Register bus geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------
   // Byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_KBASE = 8'h10;
   localparam logic [7:0] OFF_RAMSZ = 8'h40;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h80;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h90;

   // ------------------------------------------------------------
   // Control register layout
   // ------------------------------------------------------------
   localparam int CTRL_ERR_LSB = 16;
   localparam int CTRL_ERR_MSB = 20;
   localparam int CTRL_WS_BIT = 6;
   localparam int CTRL_ARB_LSB = 0;
   localparam int CTRL_ARB_MSB = 2;
   localparam logic [31:0] CTRL_RESET = 32'h001F_0041;
   localparam logic [31:0] CTRL_WMASK = 32'h001F_0047;

   // ------------------------------------------------------------
   // Kernel program base layout
   // ------------------------------------------------------------
   localparam int KBASE_LSB = 10;
   localparam int KBASE_MSB = 15;
   localparam logic [31:0] KBASE_RESET = 32'h0000_0000;
   localparam logic [31:0] KBASE_WMASK = 32'h0000_FC00;

   // ------------------------------------------------------------
   // Interrupt registers
   // ------------------------------------------------------------
   localparam int NUM_INIT = 5;
   localparam logic [4:0] IRQ_RESET = 5'h0_0;
   localparam logic [4:0] CPU_INIT_MASK = 5'h0_3;
   localparam logic [31:0] DATA_RAM_SIZE_DFLT = 32'h0000_4000;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_WRITE = 2'b00,
      OP_CLR = 2'b01,
      OP_SET = 2'b10,
      OP_INV = 2'b11
   } bmc_op_type;

   typedef enum logic [2:0] {
      ARB_MODE0 = 3'b000,
      ARB_MODE1 = 3'b001,
      ARB_MODE2 = 3'b010
   } bmc_arb_type;

   // One bit per initiator, same order as the control enables
   typedef struct packed {
      logic shared_bus;
      logic debug_unit;
      logic dma;
      logic cpu_data;
      logic cpu_instr;
   } bmc_err_type;

endpackage : bmc_pkg
`default_nettype wire

// *** verilog/bmc_alias_reg.sv ***
`timescale 1ns/100ps
`default_nettype none
module bmc_alias_reg
   import bmc_pkg::*;
#(
   parameter logic [31:0] RESET_VAL = 32'h0000_0000,
   parameter logic [31:0] WR_MASK = 32'hFFFF_FFFF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Write port
   input wire logic wr_en,
   input wire bmc_op_type op,
   input wire logic [31:0] wdata,
   // Register value
   output logic [31:0] q
);

   logic [31:0] q_reg;
   logic [31:0] q_next;
   logic [31:0] op_result;
   wire logic [31:0] w_bits = wdata & WR_MASK;

   // ------------------------------------------------------------
   // Plain write or clear, set and invert of the ones written
   // ------------------------------------------------------------
   always_comb begin
      case (op)
         OP_WRITE: op_result = w_bits;
         OP_CLR: op_result = q_reg & ~w_bits;
         OP_SET: op_result = q_reg | w_bits;
         OP_INV: op_result = q_reg ^ w_bits;
         default: op_result = q_reg;
      endcase
   end

   // Unimplemented bits can never become one
   assign q_next = wr_en ? (op_result & WR_MASK) : q_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q_reg <= RESET_VAL;
      end else begin
         q_reg <= q_next;
      end
   end

   assign q = q_reg;

endmodule : bmc_alias_reg
`default_nettype wire

// *** verilog/bmc_config.sv ***
// Behaviour
// - A set shared-bus enable lets unmapped shared-bus accesses raise a bus error, clear hides them.
// - A set debug-unit enable lets unmapped debug-unit accesses raise a bus error, clear hides them.
// - A set DMA enable lets unmapped DMA accesses raise a bus error, clear hides them.
// - A set CPU data enable raises errors for unmapped CPU data accesses, never in debug mode.
// - A set CPU fetch enable raises errors for unmapped CPU fetches, never in debug mode.
// - The wait-state bit adds one address-setup wait to CPU data RAM accesses, else none.
// - The arbitration field picks mode 0, 1 or 2 by codes 000, 001, 010 and resets to mode 1.
// - The control register has clear, set and invert aliases at offsets 0x4, 0x8 and 0xC.
// - Control bits 31 to 21 read zero and ignore writes.
// - Kernel base bits 15 to 10 are writable and hold the kernel program base in data RAM.
// - Kernel base bits 9 to 0 read zero and ignore writes, giving 1 KB steps.
// - Reset clears the kernel base so all data RAM is kernel data.
// - The data RAM size register is read-only and gives the RAM size in bytes.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module bmc_config
   import bmc_pkg::*;
#(
   parameter logic [31:0] DATA_RAM_SIZE = DATA_RAM_SIZE_DFLT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register bus
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [DATA_W-1:0] rd_data,
   // Unmapped access reports from the matrix decoder
   input wire bmc_err_type unmapped_access,
   input wire logic debug_mode,
   // Bus error exceptions to the initiators
   output var bmc_err_type bus_error,
   // CPU data RAM access handshake
   input wire logic cpu_ram_req,
   output logic cpu_ram_go,
   // Configuration to the matrix
   output logic ram_wait_state_sel,
   output logic [2:0] arbitration_mode_sel,
   output logic [5:0] kernel_program_ram_base,
   output logic [31:0] data_ram_size,
   // Interrupt
   output logic irq
);

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire bmc_op_type bus_op = bmc_op_type'(addr[3:2]);
   wire logic grp_ctrl = (addr[7:4] == OFF_CTRL[7:4]);
   wire logic grp_kbase = (addr[7:4] == OFF_KBASE[7:4]);
   wire logic hit_ctrl = (addr == OFF_CTRL);
   wire logic hit_kbase = (addr == OFF_KBASE);
   wire logic hit_ramsz = (addr == OFF_RAMSZ);
   wire logic hit_stat = (addr == OFF_IRQ_STAT);
   wire logic hit_mask = (addr == OFF_IRQ_MASK);

   // Aliases are decoded on the whole 16-byte group
   wire logic wr_ctrl = wr_strobe & grp_ctrl;
   wire logic wr_kbase = wr_strobe & grp_kbase;
   wire logic wr_stat = wr_strobe & hit_stat;
   wire logic wr_mask = wr_strobe & hit_mask;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [31:0] kbase_q;

   // Unimplemented control bits are masked out of every write
   bmc_alias_reg #(
      .RESET_VAL(CTRL_RESET),
      .WR_MASK(CTRL_WMASK)
   ) u_ctrl (
      .clk(clk),
      .nrst(nrst),
      .wr_en(wr_ctrl),
      .op(bus_op),
      .wdata(wr_data),
      .q(ctrl_q)
   );

   // Only the 1 KB granule bits of the kernel base are stored
   bmc_alias_reg #(
      .RESET_VAL(KBASE_RESET),
      .WR_MASK(KBASE_WMASK)
   ) u_kbase (
      .clk(clk),
      .nrst(nrst),
      .wr_en(wr_kbase),
      .op(bus_op),
      .wdata(wr_data),
      .q(kbase_q)
   );

   // ------------------------------------------------------------
   // Field extraction
   // ------------------------------------------------------------
   wire logic [4:0] err_en = ctrl_q[CTRL_ERR_MSB:CTRL_ERR_LSB];
   wire logic ws_sel = ctrl_q[CTRL_WS_BIT];
   wire logic [2:0] arb_sel = ctrl_q[CTRL_ARB_MSB:CTRL_ARB_LSB];

   // Passed on untouched; the arbiter owns each mode's policy
   assign arbitration_mode_sel = arb_sel;
   assign ram_wait_state_sel = ws_sel;
   assign kernel_program_ram_base = kbase_q[KBASE_MSB:KBASE_LSB];
   assign data_ram_size = DATA_RAM_SIZE;

   // ------------------------------------------------------------
   // Bus error gating
   // ------------------------------------------------------------
   wire logic [4:0] unmapped_vec = unmapped_access;
   logic [4:0] err_gate;
   logic [4:0] bus_error_reg;
   logic [4:0] bus_error_next;

   // CPU paths are silenced in debug mode whatever their enable
   genvar gi;
   generate
      for (gi = 0; gi < NUM_INIT; gi = gi + 1) begin : g_err
         if (CPU_INIT_MASK[gi]) begin : g_cpu
            assign err_gate[gi] = err_en[gi] & ~debug_mode;
         end else begin : g_other
            assign err_gate[gi] = err_en[gi];
         end
      end
   endgenerate

   assign bus_error_next = unmapped_vec & err_gate;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_error_reg <= IRQ_RESET;
      end else begin
         bus_error_reg <= bus_error_next;
      end
   end

   assign bus_error = bmc_err_type'(bus_error_reg);

   // ------------------------------------------------------------
   // CPU data RAM address setup wait
   // ------------------------------------------------------------
   logic setup_reg;
   logic setup_next;

   // With the wait bit set each access spends one cycle in setup
   assign setup_next = cpu_ram_req & ws_sel & ~setup_reg;
   assign cpu_ram_go = cpu_ram_req & (~ws_sel | setup_reg);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         setup_reg <= 1'b0;
      end else begin
         setup_reg <= setup_next;
      end
   end

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   logic [4:0] stat_reg;
   logic [4:0] stat_next;
   logic [4:0] mask_reg;
   logic [4:0] mask_next;
   wire logic [4:0] stat_clr = wr_stat ? wr_data[4:0] : IRQ_RESET;

   // A new error in the clearing cycle keeps its bit set
   assign stat_next = (stat_reg & ~stat_clr) | bus_error_reg;
   assign mask_next = wr_mask ? wr_data[4:0] : mask_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stat_reg <= IRQ_RESET;
         mask_reg <= IRQ_RESET;
      end else begin
         stat_reg <= stat_next;
         mask_reg <= mask_next;
      end
   end

   assign irq = |(stat_reg & mask_reg);

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [31:0] rd_data_reg;
   logic [31:0] rd_data_next;
   logic [31:0] rd_sel;

   // Alias addresses and holes read zero
   always_comb begin
      rd_sel = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_sel = ctrl_q;
      end else if (hit_kbase) begin
         rd_sel = kbase_q;
      end else if (hit_ramsz) begin
         rd_sel = DATA_RAM_SIZE;
      end else if (hit_stat) begin
         rd_sel = {27'h000_0000, stat_reg};
      end else if (hit_mask) begin
         rd_sel = {27'h000_0000, mask_reg};
      end
   end

   // Data stand only in the cycle after the read strobe
   assign rd_data_next = rd_strobe ? rd_sel : 32'h0000_0000;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data_reg <= 32'h0000_0000;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   assign rd_data = rd_data_reg;

endmodule : bmc_config
`default_nettype wire

// *** verif/bmc_initiators.sv ***
`timescale 1ns/100ps
`default_nettype none
module bmc_initiators (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Command and handshake
   input wire logic start,
   input wire logic cpu_ram_go,
   output logic cpu_ram_req,
   output logic [3:0] waited
);
   // -------------------------
   // CPU data RAM requester
   // -------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cpu_ram_req <= 1'b0;
         waited <= 4'h0;
      end else if (start) begin
         cpu_ram_req <= 1'b1;
         waited <= 4'h0;
      end else if (cpu_ram_req && cpu_ram_go) begin
         cpu_ram_req <= 1'b0;
      end else if (cpu_ram_req) begin
         waited <= waited + 4'h1;
      end
   end
endmodule : bmc_initiators
`default_nettype wire

// *** verif/bmc_config_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module bmc_config_properties
   import bmc_pkg::*;
#(
   parameter logic [31:0] DATA_RAM_SIZE = DATA_RAM_SIZE_DFLT
) (
   // Watched ports
   input wire logic clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic [DATA_W-1:0] rd_data,
   input wire bmc_err_type unmapped_access,
   input wire logic debug_mode,
   input wire bmc_err_type bus_error,
   input wire logic cpu_ram_req,
   input wire logic cpu_ram_go,
   input wire logic ram_wait_state_sel,
   input wire logic [2:0] arbitration_mode_sel,
   input wire logic [5:0] kernel_program_ram_base,
   input wire logic [31:0] data_ram_size,
   input wire logic irq
);
   // -------------------------
   // Properties
   // -------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   err_source_a: assert property (bus_error != 0 |->
      ($past(unmapped_access) & bus_error) == bus_error) else $error("bus error without cause");
   err_debug_a: assert property (bus_error.cpu_data || bus_error.cpu_instr |->
      !$past(debug_mode)) else $error("cpu bus error in debug mode");
   ctrl_read_a: assert property ($past(rd_strobe && addr == OFF_CTRL) |->
      rd_data[31:21] == 11'h000 && rd_data[6] == ram_wait_state_sel
      && rd_data[2:0] == arbitration_mode_sel) else $error("control read wrong");
   kbase_read_a: assert property ($past(rd_strobe && addr == OFF_KBASE) |->
      rd_data == {16'h0000, kernel_program_ram_base, 10'h000}) else $error("kbase read wrong");
   ramsz_read_a: assert property ($past(rd_strobe && addr == OFF_RAMSZ) |->
      rd_data == DATA_RAM_SIZE && data_ram_size == DATA_RAM_SIZE) else $error("size wrong");
   no_wait_a: assert property (cpu_ram_req && !ram_wait_state_sel |-> cpu_ram_go)
      else $error("zero wait access held");
   setup_wait_a: assert property (cpu_ram_req && ram_wait_state_sel && !$past(cpu_ram_req)
      |-> !cpu_ram_go) else $error("setup wait missing");
   set_alias_a: assert property (wr_strobe && addr == 8'h08 && wr_data[6]
      |=> ram_wait_state_sel) else $error("set alias failed");
   clr_alias_a: assert property (wr_strobe && addr == 8'h04 && wr_data[6]
      |=> !ram_wait_state_sel) else $error("clear alias failed");
   kbase_hold_a: assert property (!(wr_strobe && addr[7:4] == 4'h1)
      |=> $stable(kernel_program_ram_base)) else $error("kbase changed without write");
   arb_write_a: assert property (wr_strobe && addr == OFF_CTRL |=>
      arbitration_mode_sel == $past(wr_data[2:0])) else $error("arbitration field wrong");
   kbase_reset_a: assert property ($rose(nrst) |-> kernel_program_ram_base == 6'h00)
      else $error("kbase not zero after reset");
   arb_reset_a: assert property ($rose(nrst) |-> arbitration_mode_sel == 3'h1)
      else $error("arbitration mode not 1 after reset");
endmodule : bmc_config_properties
bind bmc_config bmc_config_properties #(.DATA_RAM_SIZE(DATA_RAM_SIZE)) bmc_config_properties_inst (
   .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
   .rd_strobe(rd_strobe), .rd_data(rd_data), .unmapped_access(unmapped_access),
   .debug_mode(debug_mode), .bus_error(bus_error), .cpu_ram_req(cpu_ram_req),
   .cpu_ram_go(cpu_ram_go), .ram_wait_state_sel(ram_wait_state_sel),
   .arbitration_mode_sel(arbitration_mode_sel), .kernel_program_ram_base(kernel_program_ram_base),
   .data_ram_size(data_ram_size), .irq(irq));
`default_nettype wire

// *** verif/tb_bmc_config.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_bmc_config import bmc_pkg::*;;
   // -------------------------
   // Signals
   // -------------------------
   localparam logic [31:0] RAMSZ = 32'h0000_8000;
   logic clk = 1'b0, nrst = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
   logic debug_mode = 1'b0, start = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h0000_0000;
   bmc_err_type unmapped_access = '0;
   bmc_err_type bus_error;
   logic [31:0] rd_data, data_ram_size;
   logic cpu_ram_req, cpu_ram_go, ram_wait_state_sel, irq;
   logic [2:0] arbitration_mode_sel;
   logic [5:0] kernel_program_ram_base;
   logic [3:0] waited;
   int error_cnt = 0, n_tests = 0;
   always #2 clk = ~clk;
   bmc_config #(.DATA_RAM_SIZE(RAMSZ)) bmc_config_inst (.clk(clk), .nrst(nrst), .addr(addr),
      .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
      .unmapped_access(unmapped_access), .debug_mode(debug_mode), .bus_error(bus_error),
      .cpu_ram_req(cpu_ram_req), .cpu_ram_go(cpu_ram_go), .ram_wait_state_sel(ram_wait_state_sel),
      .arbitration_mode_sel(arbitration_mode_sel), .kernel_program_ram_base(kernel_program_ram_base),
      .data_ram_size(data_ram_size), .irq(irq));
   bmc_initiators bmc_initiators_inst (.clk(clk), .nrst(nrst), .start(start),
      .cpu_ram_go(cpu_ram_go), .cpu_ram_req(cpu_ram_req), .waited(waited));
   // -------------------------
   // Tasks
   // -------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge clk);
      wr_strobe <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge clk);
      rd_strobe <= 1'b0;
      #1;
      chk("rd_data", exp, rd_data);
   endtask : rd
   task automatic hit(input logic [4:0] b, input logic dbg, input logic [31:0] exp);
      @(posedge clk);
      unmapped_access <= b;
      debug_mode <= dbg;
      @(posedge clk);
      unmapped_access <= '0;
      debug_mode <= 1'b0;
      #1;
      chk("bus_error", exp, {27'h000_0000, bus_error});
   endtask : hit
   task automatic ram(input logic [31:0] exp);
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("waited", exp, {28'h000_0000, waited});
      chk("cpu_ram_req", 32'h0000_0000, {31'h0000_0000, cpu_ram_req});
   endtask : ram
   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   // -------------------------
   // Tests
   // -------------------------
   initial begin
      #40000;
      error_cnt++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rd(OFF_CTRL, 32'h001F_0041);
      rd(OFF_KBASE, 32'h0000_0000);
      rd(OFF_RAMSZ, RAMSZ);
      for (int i = 0; i < 3; i++) begin
         wr(OFF_CTRL, 32'h001F_0040 | 32'(i));
         chk("arb", 32'(i), {29'h0000_0000, arbitration_mode_sel});
      end
      wr(OFF_CTRL, 32'hFFFF_FFBA);
      rd(OFF_CTRL, 32'h001F_0002);
      wr(8'h04, 32'h0001_0000);
      rd(OFF_CTRL, 32'h001E_0002);
      wr(8'h08, 32'h0000_0040);
      rd(OFF_CTRL, 32'h001E_0042);
      wr(8'h0C, 32'h0003_0040);
      rd(OFF_CTRL, 32'h001D_0002);
      wr(8'h08, 32'h001F_0000);
      rd(8'h08, 32'h0000_0000);
      wr(OFF_KBASE, 32'h0000_3FFF);
      rd(OFF_KBASE, 32'h0000_3C00);
      chk("kbase", 32'h0000_000F, {26'h000_0000, kernel_program_ram_base});
      wr(8'h1C, 32'hFFFF_0400);
      rd(OFF_KBASE, 32'h0000_3800);
      wr(OFF_RAMSZ, 32'h0000_0000);
      rd(OFF_RAMSZ, RAMSZ);
      rd(8'h20, 32'h0000_0000);
      wr(OFF_IRQ_MASK, 32'h0000_001F);
      for (int i = 0; i < 5; i++) hit(5'(1 << i), 1'b0, 32'(1 << i));
      rd(OFF_IRQ_STAT, 32'h0000_001F);
      chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
      wr(OFF_IRQ_STAT, 32'h0000_001F);
      chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
      wr(8'h04, 32'h001F_0000);
      hit(5'h1F, 1'b0, 32'h0000_0000);
      rd(OFF_IRQ_STAT, 32'h0000_0000);
      wr(8'h08, 32'h001F_0000);
      hit(5'h1F, 1'b1, 32'h0000_001C);
      hit(5'h03, 1'b0, 32'h0000_0003);
      wr(OFF_IRQ_MASK, 32'h0000_0000);
      chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
      ram(32'h0000_0000);
      wr(8'h08, 32'h0000_0040);
      ram(32'h0000_0001);
      wr(8'h04, 32'h0000_0040);
      ram(32'h0000_0000);
      @(posedge clk);
      nrst <= 1'b0;
      @(posedge clk);
      #1;
      chk("kbase", 32'h0000_0000, {26'h000_0000, kernel_program_ram_base});
      chk("arb", 32'h0000_0001, {29'h0000_0000, arbitration_mode_sel});
      @(posedge clk);
      nrst <= 1'b1;
      rd(OFF_KBASE, 32'h0000_0000);
      test_done();
   end
endmodule : tb_bmc_config
`default_nettype wire
